// File: hw/ewss_defs.svh
`ifndef EWSS_DEFS_SVH
`define EWSS_DEFS_SVH

// Strobe levels
`define EWSS_STROBE_IDLE 1'h1
`define EWSS_STROBE_ACT  1'h0
// Byte enable encoding {high, low}
`define EWSS_BE_WIDTH    2
`define EWSS_BE_LOW      2'h1
`define EWSS_BE_HIGH     2'h2
`define EWSS_BE_WORD     2'h3

`endif

// File: hw/ewss_pkg.sv
package ewss_pkg;
	typedef enum logic [2:0] {
		EWSS_IDLE  = 3'b001,
		EWSS_WIDTH = 3'b010,
		EWSS_WRITE = 3'b100
	} ewss_state_e;
endpackage

// File: hw/ewss_write_strobe.sv
`include "ewss_defs.svh"

// Function
// - Single write strobe low only during an external write, otherwise high.
// - Port five bit two pin carries single strobe when style bit set, else low strobe.
// - Port five bit five pin carries byte high enable when style bit set, else high strobe.
// - Sixteen-bit cycles assert high strobe for high-byte and word writes.
// - Eight-bit cycles assert high strobe on every write.
// - Sixteen-bit cycles assert low strobe for low-byte and word writes.
// - Eight-bit cycles assert low strobe on every write.
// - All timing runs from the oscillator-derived internal clock.
module ewss_write_strobe
	import ewss_pkg::*;
#(
	parameter int unsigned BE_WIDTH = `EWSS_BE_WIDTH
)
(
	input  wire logic                       mclk,
	input  wire logic                       srst,
	input  wire logic                       clk_en,
	input  wire logic                       wr_req,
	input  wire logic [BE_WIDTH-1:0]        wr_byte_en,
	input  wire logic                       bus_16bit,
	input  wire logic                       write_strobe_style_bit,
	output logic                            port_five_bit_two,
	output logic                            port_five_bit_five,
	output logic                            wr_busy
);

	////////////////////////////////////////////////////////////////////////////////
	// Cycle sequencer

	ewss_state_e                  state_q;
	ewss_state_e                  state_d;
	logic                         wide_q;
	logic                         wide_d;
	logic [BE_WIDTH-1:0]          be_q;
	logic [BE_WIDTH-1:0]          be_d;
	logic                         pin_two_q;
	logic                         pin_two_d;
	logic                         pin_five_q;
	logic                         pin_five_d;
	logic                         strobe_on;
	logic                         hi_on;
	logic                         lo_on;
	logic                         busy_d;
	logic                         take;

	////////////////////////////////////////////////////////////////////////////////
	// Parameter check

	if (BE_WIDTH != 2) begin : g_bad_width
		$error("byte enable width must be two");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic strobe_level(input logic active);
		return active ? `EWSS_STROBE_ACT : `EWSS_STROBE_IDLE;
	endfunction

	function automatic logic lane_on(input logic wide, input logic lane);
		return !wide || lane;
	endfunction

	// Request with a nonempty byte set
	assign take = wr_req && (wr_byte_en != '0);

	always_comb begin
		state_d = state_q;
		wide_d  = wide_q;
		be_d    = be_q;
		unique case (state_q)
			EWSS_IDLE: begin
				if (take) begin
					wide_d  = bus_16bit;
					be_d    = wr_byte_en;
					state_d = EWSS_WIDTH;
				end
			end
			EWSS_WIDTH: begin
				state_d = EWSS_WRITE;
			end
			EWSS_WRITE: begin
				state_d = EWSS_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strobe and pin selection

	always_comb begin
		strobe_on = (state_d == EWSS_WRITE);
		busy_d    = (state_d != EWSS_IDLE);
		hi_on     = strobe_on && lane_on(wide_d, be_d[1]);
		lo_on     = strobe_on && lane_on(wide_d, be_d[0]);
		if (write_strobe_style_bit) begin
			pin_two_d  = strobe_level(strobe_on);
			pin_five_d = strobe_level(busy_d && wide_d && be_d[1]);
		end else begin
			pin_two_d  = strobe_level(lo_on);
			pin_five_d = strobe_level(hi_on);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q    <= EWSS_IDLE;
			wide_q     <= 1'b0;
			be_q       <= 2'h0;
			pin_two_q  <= `EWSS_STROBE_IDLE;
			pin_five_q <= `EWSS_STROBE_IDLE;
			wr_busy    <= 1'b0;
		end else if (clk_en) begin
			state_q    <= state_d;
			wide_q     <= wide_d;
			be_q       <= be_d;
			pin_two_q  <= pin_two_d;
			pin_five_q <= pin_five_d;
			wr_busy    <= busy_d;
		end
	end

	assign port_five_bit_two  = pin_two_q;
	assign port_five_bit_five = pin_five_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	logic is_write;
	assign is_write = (state_q == EWSS_WRITE);

	a_single_strobe_only: assert property (@(posedge mclk) disable iff (srst)
		write_strobe_style_bit |-> (port_five_bit_two == !is_write))
		else $error("single strobe not tied to write phase");

	a_idle_pins_high: assert property (@(posedge mclk) disable iff (srst)
		(state_q == EWSS_IDLE) |-> (port_five_bit_two && port_five_bit_five))
		else $error("strobe active outside a write");

	a_narrow_high_strobe: assert property (@(posedge mclk) disable iff (srst)
		(is_write && !wide_q && !write_strobe_style_bit) |-> !port_five_bit_five)
		else $error("high strobe missing in narrow cycle");

	a_narrow_low_strobe: assert property (@(posedge mclk) disable iff (srst)
		(is_write && !wide_q && !write_strobe_style_bit) |-> !port_five_bit_two)
		else $error("low strobe missing in narrow cycle");

	a_wide_high_strobe: assert property (@(posedge mclk) disable iff (srst)
		(is_write && wide_q && !write_strobe_style_bit) |-> (port_five_bit_five == !be_q[1]))
		else $error("high strobe wrong in wide cycle");

	a_wide_low_strobe: assert property (@(posedge mclk) disable iff (srst)
		(is_write && wide_q && !write_strobe_style_bit) |-> (port_five_bit_two == !be_q[0]))
		else $error("low strobe wrong in wide cycle");

	a_byte_high_en: assert property (@(posedge mclk) disable iff (srst)
		(is_write && write_strobe_style_bit) |-> (port_five_bit_five == !(wide_q && be_q[1])))
		else $error("byte high enable wrong");

	a_narrow_bhe_high: assert property (@(posedge mclk) disable iff (srst)
		(write_strobe_style_bit && !wide_q) |-> port_five_bit_five)
		else $error("byte high enable low in narrow cycle");

	a_width_held: assert property (@(posedge mclk) disable iff (srst || !clk_en)
		(state_q == EWSS_WIDTH) |=> (is_write && $stable(wide_q)))
		else $error("width changed before strobe");

	a_setup_no_strobe: assert property (@(posedge mclk) disable iff (srst)
		(state_q == EWSS_WIDTH) |->
		(port_five_bit_two && (write_strobe_style_bit || port_five_bit_five)))
		else $error("strobe active before width settled");

	a_take_width_phase: assert property (@(posedge mclk) disable iff (srst)
		(state_q == EWSS_IDLE && take && clk_en) |=> (state_q == EWSS_WIDTH))
		else $error("request not taken into setup");

	a_busy_on_take: assert property (@(posedge mclk) disable iff (srst)
		(state_q == EWSS_IDLE && take && clk_en) |=> wr_busy)
		else $error("busy missing after request");

	a_empty_refused: assert property (@(posedge mclk) disable iff (srst)
		(state_q == EWSS_IDLE && !take && clk_en) |=> (state_q == EWSS_IDLE))
		else $error("write started without request");

	a_sequence_len: assert property (@(posedge mclk) disable iff (srst || !clk_en)
		(state_q == EWSS_IDLE && take) |=> ##1 is_write ##1
		(state_q == EWSS_IDLE))
		else $error("write sequence length wrong");

	a_strobe_one_cycle: assert property (@(posedge mclk) disable iff (srst)
		(is_write && clk_en) |=> !is_write)
		else $error("write phase too long");

	a_low_pin_release: assert property (@(posedge mclk) disable iff (srst)
		(is_write && clk_en) |=> port_five_bit_two)
		else $error("pin two not released after write");

	a_high_pin_release: assert property (@(posedge mclk) disable iff (srst)
		(is_write && clk_en) |=> port_five_bit_five)
		else $error("pin five not released after write");

	a_freeze_pins: assert property (@(posedge mclk) disable iff (srst)
		!clk_en |=> ($stable(port_five_bit_two) && $stable(port_five_bit_five)))
		else $error("pins moved while frozen");

	a_freeze_state: assert property (@(posedge mclk) disable iff (srst)
		!clk_en |=> ($stable(state_q) && $stable(wr_busy)))
		else $error("sequence moved while frozen");

	a_reset_pins: assert property (@(posedge mclk)
		srst |=> (port_five_bit_two && port_five_bit_five && !wr_busy))
		else $error("pins not idle after reset");

	////////////////////////////////////////////////////////////////////////////////
	// Coverage

	c_wide_word: cover property (@(posedge mclk) is_write && wide_q && be_q == `EWSS_BE_WORD);
	c_wide_high: cover property (@(posedge mclk) is_write && wide_q && be_q == `EWSS_BE_HIGH);
	c_narrow_low: cover property (@(posedge mclk) is_write && !wide_q && be_q == `EWSS_BE_LOW);
	c_single_style: cover property (@(posedge mclk) is_write && write_strobe_style_bit);
	c_frozen_write: cover property (@(posedge mclk) is_write && !clk_en);

endmodule

// File: verification/ewss_ext_mem.sv
// Far-side memory: counts low-byte or single strobe pulses
module ewss_ext_mem (
	input  wire logic mclk,
	input  wire logic srst,
	input  wire logic low_strobe_n,
	output int        n_low
);
	timeunit 1ns;
	timeprecision 100ps;
	logic last_n;
	always_ff @(posedge mclk) begin
		if (srst) begin
			n_low  <= 0;
			last_n <= 1'h1;
		end else begin
			last_n <= low_strobe_n;
			if (low_strobe_n === 1'h0 && last_n === 1'h1)
				n_low <= n_low + 1;
		end
	end
endmodule

// File: verification/ewss_write_strobe_tb_top.sv
module ewss_write_strobe_tb_top;
	import ewss_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic       mclk = 0, srst = 1, clk_en = 1, wr_req = 0, wide = 0, style = 0;
	logic [1:0] be = 2'h0;
	logic       p2, p5, busy, l, h;
	int         mismatches = 0, n_tests = 0, exp_cnt = 0, mem_cnt;
	// Rows {wide, bytes, low pin, high pin} for separate strobes
	logic [4:0] rows [6] = '{5'h04, 5'h08, 5'h0c, 5'h15, 5'h1a, 5'h1c};
	ewss_write_strobe DUT (.mclk(mclk), .srst(srst), .clk_en(clk_en), .wr_req(wr_req),
		.wr_byte_en(be), .bus_16bit(wide), .write_strobe_style_bit(style),
		.port_five_bit_two(p2), .port_five_bit_five(p5), .wr_busy(busy));
	ewss_ext_mem mem (.mclk(mclk), .srst(srst), .low_strobe_n(p2), .n_low(mem_cnt));
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task ck(input logic a, input logic e);
		n_tests++;
		if (a !== e) begin
			mismatches++;
			$display("CHECK FAILED %0t pin mismatch", $time);
		end
	endtask
	task final_report;
		if (mismatches == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task do_wr(input logic s, input logic w, input logic [1:0] b);
		@(posedge mclk);
		style <= s;
		wide <= w;
		be <= b;
		wr_req <= 1'h1;
		@(posedge mclk);
		wr_req <= 1'h0;
		#1 ck(busy, 1'h1);
		ck(p5, s ? h : 1'h1);
		@(posedge mclk);
		#1 ck(p2, l);
		ck(p5, h);
		@(posedge mclk);
		#1 ck(p2, 1'h1);
		ck(p5, 1'h1);
		ck(busy, 1'h0);
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		srst <= 1'h0;
		#1 ck(p2, 1'h1);
		ck(p5, 1'h1);
		for (int s = 0; s < 2; s++) begin
			for (int r = 0; r < 6; r++) begin
				l = s ? 1'h0 : rows[r][1];
				h = s ? !(rows[r][4] && rows[r][3]) : rows[r][0];
				exp_cnt += !l;
				do_wr(s[0], rows[r][4], rows[r][3:2]);
			end
		end
		// Empty byte set is ignored
		@(posedge mclk);
		be <= 2'h0;
		wr_req <= 1'h1;
		@(posedge mclk);
		wr_req <= 1'h0;
		#1 ck(busy, 1'h0);
		@(posedge mclk);
		#1 ck(p2, 1'h1);
		// Low clock enable holds the strobe
		@(posedge mclk);
		style <= 1'h0;
		wide <= 1'h1;
		be <= 2'h3;
		wr_req <= 1'h1;
		@(posedge mclk);
		wr_req <= 1'h0;
		@(posedge mclk);
		clk_en <= 1'h0;
		repeat (2) @(posedge mclk);
		#1 ck(p2, 1'h0);
		ck(p5, 1'h0);
		ck(busy, 1'h1);
		@(posedge mclk);
		clk_en <= 1'h1;
		@(posedge mclk);
		#1 ck(p2, 1'h1);
		ck(busy, 1'h0);
		exp_cnt += 1;
		ck(mem_cnt == exp_cnt, 1'h1);
		// Reset in mid-write
		@(posedge mclk);
		wr_req <= 1'h1;
		@(posedge mclk);
		wr_req <= 1'h0;
		srst <= 1'h1;
		@(posedge mclk);
		#1 ck(p2, 1'h1);
		ck(p5, 1'h1);
		ck(busy, 1'h0);
		@(posedge mclk);
		srst <= 1'h0;
		l = 1'h0;
		h = 1'h0;
		do_wr(1'h0, 1'h1, 2'h3);
		final_report();
	end
endmodule
